/* hdl/tps_timer_regs.svh */
// Register map, field positions and reset values of the timer block
`ifndef TPS_TIMER_REGS_SVH
`define TPS_TIMER_REGS_SVH

// Register indexes; byte address is four times the index
`define TPS_IDX_COUNT      9'h001
`define TPS_IDX_INTCTRL    9'h00b
`define TPS_IDX_OPTION     9'h081
`define TPS_ADDR_W         12

// Option register fields
`define TPS_OPT_SRC_BIT    5
`define TPS_OPT_EDGE_BIT   4
`define TPS_OPT_PSA_BIT    3
`define TPS_OPT_RATE_HI    2
`define TPS_OPT_RATE_LO    0

// Interrupt control register fields
`define TPS_INT_EN_BIT     5
`define TPS_INT_FLAG_BIT   2

// Reset values
`define TPS_RST_OPTION     8'hff
`define TPS_RST_COUNT      8'h00
`define TPS_RST_INTCTRL    8'h00

// Instruction cycles suppressed after a count register write
`define TPS_WR_HOLD_CYC    2'h2

`endif

/* hdl/tps_timer_pkg.sv */
// Types shared by the timer block
package tps_timer_pkg;

    typedef struct packed {
        logic       pullup_n;
        logic       int_edge;
        logic       count_source_select;
        logic       count_edge_select;
        logic       prescaler_assign_bit;
        logic [2:0] prescale_rate_bits;
    } tps_option_t;

    typedef enum logic [1:0] {
        TPS_ACC_IDLE  = 2'b00,
        TPS_ACC_SETUP = 2'b01,
        TPS_ACC_WAIT  = 2'b10
    } tps_acc_t;

    typedef struct packed {
        logic       inc;
        logic       wrap;
    } tps_tick_t;

endpackage : tps_timer_pkg

/* hdl/tps_timer.sv */
// Eight-bit timer with prescaler shared with the watchdog, APB slave
//
// Notes on behaviour
// - Source zero counts instruction cycles
// - Count write suppresses two instruction cycles
// - Source one counts external pin edges
// - Edge bit: zero rising, one falling
// - External pin synchronised before use
// - Eight-bit count, software access, wraps
// - One prescaler, timer or watchdog only
// - Prescaler count never visible to software
// - Timer assignment: ratios 1:2 to 1:256
// - Watchdog assignment: ratios 1:1 to 1:128
// - Count write clears prescaler when timer-assigned, keeps assignment
// - Watchdog clear clears watchdog, and prescaler when watchdog-assigned
// - Assignment changeable at any time
// - Overflow sets overflow flag bit 2
// - Enable bit 5 masks interrupt request
// - Counter stops during sleep
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "tps_timer_regs.svh"

module tps_timer
    import tps_timer_pkg::*;
#(
    parameter int INSTR_DIV = 1
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`TPS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // External count pin
    input  wire logic                   external_count_pin,
    // Core status
    input  wire logic                   sleep_mode,
    input  wire logic                   watchdog_clear_instruction,
    input  wire logic                   watchdog_unit_tick,
    // Watchdog side and interrupt
    output logic                        watchdog_unit_clear,
    output logic                        watchdog_unit_tick_out,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

    tps_option_t      opt_q;
    logic [7:0]       timer_count_reg_q;
    logic [7:0]       count_d;
    logic             overflow_flag_q;
    logic             overflow_irq_enable_q;
    logic [7:0]       presc_q;
    logic [7:0]       presc_d;
    logic [1:0]       hold_q;
    logic [DIV_W-1:0] div_q;
    logic             pin_s1_q;
    logic             pin_s2_q;
    logic             pin_s3_q;
    logic [31:0]      prdata_q;
    logic             wdt_out_q;

    logic             instr_en;
    logic             rise_ev;
    logic             fall_ev;
    logic             ext_ev;
    logic             src_ev;
    logic             gated_ev;
    logic             presc_in;
    logic [7:0]       rate_mask;
    logic             presc_hit;
    tps_tick_t        tick;
    logic [`TPS_ADDR_W-3:0] wr_idx;
    logic             wr_en;
    logic             rd_setup;
    logic             hit_count;
    logic             hit_int;
    logic             hit_opt;
    logic             addr_ok;
    logic             wr_count;
    logic             wr_int;
    logic             wr_opt;
    logic [7:0]       int_view;
    logic [7:0]       rd_byte;

    ////////////////////////////////////////////////////////////////////////
    // Mask selecting the prescaler bits for a ratio of 2 to the n

    function automatic logic [7:0] rate_to_mask(input logic [3:0] n);
        rate_to_mask = 8'hff >> (4'h8 - n);
    endfunction : rate_to_mask

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    assign wr_idx    = paddr[`TPS_ADDR_W-1:2];
    assign hit_count = (wr_idx == `TPS_IDX_COUNT);
    assign hit_int   = (wr_idx == `TPS_IDX_INTCTRL);
    assign hit_opt   = (wr_idx == `TPS_IDX_OPTION);
    assign addr_ok   = (hit_count | hit_int | hit_opt) & (paddr[1:0] == 2'h0);
    assign wr_en     = psel & penable & pwrite & addr_ok;
    assign rd_setup  = psel & ~penable;
    assign wr_count  = wr_en & hit_count;
    assign wr_int    = wr_en & hit_int;
    assign wr_opt    = wr_en & hit_opt;

    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = prdata_q;

    assign int_view = {2'h0, overflow_irq_enable_q, 2'h0, overflow_flag_q,
                       2'h0};
    assign rd_byte  = hit_count ? timer_count_reg_q :
                      hit_int   ? int_view :
                      hit_opt   ? opt_q : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle enable

    generate
        if (INSTR_DIV > 1) begin : g_div
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    div_q <= '0;
                end else if (div_q == DIV_W'(INSTR_DIV - 1)) begin
                    div_q <= '0;
                end else begin
                    div_q <= div_q + DIV_W'(1);
                end
            end
            assign instr_en = (div_q == DIV_W'(INSTR_DIV - 1));
        end else begin : g_nodiv
            assign div_q    = '0;
            assign instr_en = 1'b1;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // External pin synchroniser and edge detect

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= external_count_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign rise_ev = pin_s2_q & ~pin_s3_q;
    assign fall_ev = ~pin_s2_q & pin_s3_q;
    assign ext_ev  = opt_q.count_edge_select ? fall_ev : rise_ev;
    assign src_ev  = opt_q.count_source_select ? ext_ev : instr_en;
    // stopped in sleep; suppress after write
    assign gated_ev = src_ev & ~sleep_mode & (hold_q == 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // Shared prescaler

    // one prescaler, routed by live assignment bit
    assign presc_in = opt_q.prescaler_assign_bit ? watchdog_unit_tick
                                                 : gated_ev;
    assign rate_mask = opt_q.prescaler_assign_bit ?
                       rate_to_mask({1'b0, opt_q.prescale_rate_bits}) :
                       rate_to_mask({1'b0, opt_q.prescale_rate_bits} + 4'h1);
    assign presc_hit = presc_in & ((presc_q & rate_mask) == rate_mask);

    always_comb begin
        presc_d = presc_q;
        if (presc_in) begin
            presc_d = presc_q + 8'h01;
        end
        if (wr_count && !opt_q.prescaler_assign_bit) begin
            presc_d = 8'h00;
        end
        if (watchdog_clear_instruction && opt_q.prescaler_assign_bit) begin
            presc_d = 8'h00;
        end
    end

    assign tick.inc  = opt_q.prescaler_assign_bit ? gated_ev : presc_hit;
    assign tick.wrap = tick.inc & (timer_count_reg_q == 8'hff);

    assign watchdog_unit_clear    = watchdog_clear_instruction;
    assign watchdog_unit_tick_out = wdt_out_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q   <= 8'h00;
            wdt_out_q <= 1'b0;
        end else begin
            presc_q   <= presc_d;
            wdt_out_q <= presc_hit & opt_q.prescaler_assign_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count register

    always_comb begin
        count_d = timer_count_reg_q;
        if (wr_count) begin
            count_d = pwdata[7:0];
        end else if (tick.inc) begin
            count_d = timer_count_reg_q + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count_reg_q <= `TPS_RST_COUNT;
        end else begin
            timer_count_reg_q <= count_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 2'h0;
        end else if (wr_count) begin
            hold_q <= `TPS_WR_HOLD_CYC;
        end else if (instr_en && hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Option and interrupt control registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_q <= tps_option_t'(`TPS_RST_OPTION);
        end else if (wr_opt) begin
            opt_q <= tps_option_t'(pwdata[7:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq_enable_q <= 1'(`TPS_RST_INTCTRL >> `TPS_INT_EN_BIT);
            overflow_flag_q       <= 1'b0;
        end else begin
            if (wr_int) begin
                overflow_irq_enable_q <= pwdata[`TPS_INT_EN_BIT];
            end
            // overflow sets flag, set beats clear
            if (tick.wrap) begin
                overflow_flag_q <= 1'b1;
            end else if (wr_int && pwdata[`TPS_INT_FLAG_BIT]) begin
                overflow_flag_q <= 1'b0;
            end
        end
    end

    assign irq = overflow_flag_q & overflow_irq_enable_q;

    ////////////////////////////////////////////////////////////////////////
    // Read data capture in the setup cycle

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= {24'h00_0000, rd_byte};
        end
    end

endmodule : tps_timer

/* verification/tps_timer_monitor.sv */
// Port checker for the timer block
`timescale 1ns/100ps
module tps_timer_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Core side
    input wire logic        sleep_mode,
    input wire logic        watchdog_clear_instruction,
    input wire logic        watchdog_unit_tick,
    input wire logic        watchdog_unit_clear,
    input wire logic        watchdog_unit_tick_out,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire rd  = acc && !pwrite;
    wire icw = acc && pwrite && paddr == 12'h02c;
    wire map = paddr inside {12'h004, 12'h02c, 12'h204};
    ////////////////////////////////////////
    ready_a:
        assert property (acc |-> pready) else $error("no ready");
    unmapped_a:
        assert property (rd && !map |-> pslverr && prdata == 0)
        else $error("unmapped read");
    read_pad_a:
        assert property (rd |-> prdata[31:8] == 0) else $error("high bits");
    irq_read_a:
        assert property (rd && paddr == 12'h02c |->
            $past(irq) == (prdata[5] && prdata[2])) else $error("irq mask");
    irq_fall_a:
        assert property ($fell(irq) |-> $past(icw)) else $error("irq fell");
    irq_sleep_a:
        assert property ($rose(irq) |-> $past(!sleep_mode || icw))
        else $error("irq in sleep");
    wd_clear_a:
        assert property (watchdog_unit_clear == watchdog_clear_instruction)
        else $error("wd clear");
    wd_tick_a:
        assert property (watchdog_unit_tick_out |-> $past(watchdog_unit_tick))
        else $error("wd tick");
endmodule : tps_timer_monitor

bind tps_timer tps_timer_monitor tps_timer_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .watchdog_unit_tick(watchdog_unit_tick),
    .watchdog_unit_clear(watchdog_unit_clear),
    .watchdog_unit_tick_out(watchdog_unit_tick_out), .irq(irq));

/* verification/tps_pin_model.sv */
// Driver model of the external count pin
`timescale 1ns/100ps
module tps_pin_model (
    // Clock
    input  wire logic       pclk,
    // Command from the bench
    input  wire logic       level,
    input  wire logic [3:0] npulse,
    input  wire logic       go,
    // Pin side
    output logic            external_count_pin,
    output logic            busy
);
    logic [5:0] ph_q = 6'h00;
    always_ff @(posedge pclk) begin
        if (go && !busy) begin
            ph_q <= {npulse, 2'b00};
        end else if (busy) begin
            ph_q <= ph_q - 6'h01;
        end
    end
    assign busy = ph_q != 6'h00;
    // Two-cycle phases, long enough for the synchroniser
    assign external_count_pin = level ^ ph_q[1];
endmodule : tps_pin_model

/* verification/tps_timer_tb.sv */
// Self-checking bench for the timer block
`timescale 1ns/100ps
module tps_timer_tb;
    localparam logic [11:0] a_cnt = 12'h004;
    localparam logic [11:0] a_int = 12'h02c;
    localparam logic [11:0] a_opt = 12'h204;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        irq, pin, sleep_mode, wclr, wtick, wtick_o, level, go;
    logic        busy, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r1, r2;
    logic [7:0]  v;
    logic [3:0]  npulse;
    int          num_errors = 0;
    int          checks = 0;
    int          tcnt = 0;
    int          t0;

    tps_timer tps_timer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_pin(pin),
        .sleep_mode(sleep_mode), .watchdog_clear_instruction(wclr),
        .watchdog_unit_tick(wtick), .watchdog_unit_clear(),
        .watchdog_unit_tick_out(wtick_o), .irq(irq));
    tps_pin_model tps_pin_model_i (.pclk(pclk), .level(level),
        .npulse(npulse), .go(go), .external_count_pin(pin), .busy(busy));
    ////////////////////////////////////////
    function automatic logic [31:0] ecnt(input logic [7:0] b, input int n);
        return {24'h0, b + 8'(n)};
    endfunction : ecnt
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r1 = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(r1, e);
    endtask : rd
    task automatic tick(input logic c);
        @(posedge pclk);
        wclr <= c;
        wtick <= !c;
        @(posedge pclk);
        wclr <= 1'b0;
        wtick <= 1'b0;
    endtask : tick
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) if (wtick_o === 1'b1) tcnt++;
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {sleep_mode, wclr, wtick, level, go, npulse} = '0;
        v = 8'($urandom(32'hd61ba9bf));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(a_opt, 32'hff);
        rd(a_cnt, 32'h0);
        rd(a_int, 32'h0);
        rd(12'h008, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("reset values done");
        apb(1'b1, a_opt, 8'h08);
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 8'hfe : 8'($urandom);
            apb(1'b1, a_cnt, v);
            rd(a_cnt, ecnt(v, 0));
            rd(a_cnt, ecnt(v, 2));
        end
        sleep_mode <= 1'b1;
        apb(1'b1, a_cnt, 8'h5a);
        repeat (4) @(posedge pclk);
        rd(a_cnt, 32'h5a);
        rd(a_int, 32'h04);
        apb(1'b1, a_int, 8'h20);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, a_int, 8'h24);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(a_int, 32'h20);
        sleep_mode <= 1'b0;
        $display("timer and flag done");
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, a_opt, 8'(r));
            apb(1'b0, a_cnt, 8'h00);
            r2 = r1;
            repeat ((4 << r) - 3) @(posedge pclk);
            apb(1'b0, a_cnt, 8'h00);
            chk((r1 - r2) & 32'hff, 32'h2);
        end
        apb(1'b1, a_opt, 8'h02);
        apb(1'b1, a_cnt, 8'h00);
        repeat (9) @(posedge pclk);
        rd(a_cnt, 32'h1);
        $display("timer ratios done");
        for (int r = 0; r < 8; r++) begin
            tick(1'b1);
            apb(1'b1, a_opt, 8'h08 | 8'(r));
            tick(1'b1);
            t0 = tcnt;
            repeat (2 << r) tick(1'b0);
            repeat (3) @(posedge pclk);
            chk(tcnt - t0, 32'h2);
        end
        apb(1'b1, a_opt, 8'h00);
        t0 = tcnt;
        repeat (8) tick(1'b0);
        repeat (3) @(posedge pclk);
        chk(tcnt - t0, 32'h0);
        $display("watchdog ratios done");
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, a_opt, 8'h28 | 8'(e << 4));
            apb(1'b1, a_cnt, 8'h00);
            repeat (4) @(posedge pclk);
            level <= 1'b1;
            repeat (8) @(posedge pclk);
            rd(a_cnt, 32'(1 - e));
            level <= 1'b0;
            repeat (8) @(posedge pclk);
            rd(a_cnt, 32'h1);
            npulse <= 4'($urandom_range(15, 1));
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            @(posedge pclk);
            while (busy) @(posedge pclk);
            repeat (8) @(posedge pclk);
            rd(a_cnt, 32'(1 + npulse));
        end
        $display("external count done");
        report_and_stop();
    end
endmodule : tps_timer_tb
